/* File: inc/tsm_map.vh */
// constants, register map and field positions for the timer split-mode block
// Contract
// R01: timer 0 mode 3 splits timer 0 into two separate 8-bit counters.
// R02: low byte uses timer 0 run, counter select, gate and overflow flag.
// R03: low byte counts the timer clock or external pin, per counter select.
// R04: high byte is timer only, system or prescaled clock, never pin.
// R05: high byte counts only while timer 1 run bit is set.
// R06: high byte overflow sets timer 1 overflow flag and interrupt.
// R07: timer 1 in modes 0-2 during split: no pin counting, no flag.
// R08: timer 1 overflow pulse stays available for baud rate and ADC start.
// R09: during split, timer 1 runs in modes 0-2 and stops in mode 3.
// R10: hardware sets each overflow flag when its counter overflows.
// R11: overflow flags cleared by software write or on interrupt vectoring.
// R12: a timer is enabled by writing 1 to its run bit, gate permitting.
// R13: type bit 0 selects level, 1 selects edge external interrupt detection.
// R14: separate polarity bit sets active sense for edge and level detection.
// R15: control register at 0x88, bit addressable, on every register page.
// R16: external flag set on edge or level; auto clear on vector edge only.
// R17: each timer has four modes: 13-bit, 16-bit, 8-bit reload, mode 3.
// R18: clock select bit picks system clock, else prescaled clock.
// R19: counter mode increments on each falling edge of the count pin.
// R20: gate set: run bit and active external input; clear: run bit alone.
`ifndef TSM_MAP_VH
`define TSM_MAP_VH

`define TSM_ADDR_TIMER_CONTROL   8'h88
`define TSM_ADDR_TIMER_MODE_REGISTER   8'h89
`define TSM_ADDR_TL0    8'h8a
`define TSM_ADDR_TL1    8'h8b
`define TSM_ADDR_TH0    8'h8c
`define TSM_ADDR_TH1    8'h8d
`define TSM_ADDR_CLOCK_CONTROL_REGISTER  8'h8e

`define TSM_BYTE_ZERO   8'h00
`define TSM_BYTE_ONES   8'hff
`define TSM_BIT_ONE     8'h01
`define TSM_RST_BYTE    8'h00
`define TSM_RST_CNT     6'h00

`define TSM_TC_TF1      7
`define TSM_TC_TR1      6
`define TSM_TC_TF0      5
`define TSM_TC_TR0      4
`define TSM_TC_IE1      3
`define TSM_TC_IT1      2
`define TSM_TC_IE0      1
`define TSM_TC_IT0      0

`define TSM_TM_GATE1    7
`define TSM_TM_CT1      6
`define TSM_TM_M1_HI    5
`define TSM_TM_M1_LO    4
`define TSM_TM_TIMER0_GATE_ENABLE    3
`define TSM_TM_CT0      2
`define TSM_TM_M0_HI    1
`define TSM_TM_M0_LO    0

`define TSM_CK_T1SYS    3
`define TSM_CK_T0SYS    2
`define TSM_CK_SCA_HI   1
`define TSM_CK_SCA_LO   0

`define TSM_MODE_13     2'b00
`define TSM_MODE_16     2'b01
`define TSM_MODE_RLD    2'b10
`define TSM_MODE_SPLIT  2'b11

`define TSM_SCA_DIV12   2'b00
`define TSM_SCA_DIV4    2'b01
`define TSM_SCA_DIV48   2'b10
`define TSM_SCA_EXT8    2'b11
`define TSM_LAST_DIV12  6'h0b
`define TSM_LAST_DIV4   6'h03
`define TSM_LAST_DIV48  6'h2f
`define TSM_LAST_EXT8   6'h07

`define TSM_TL13_MSB    4
`define TSM_TL13_PAD    5

`endif

/* File: rtl/tsm_prescaler.v */
// timer 0/1 clock prescaler producing a one-cycle count tick
`timescale 1ns/100ps
`include "tsm_map.vh"
module tsm_prescaler (
  input  wire       mclk,
  input  wire       rst,
  input  wire       ce,
  input  wire [1:0] sca,
  input  wire       ext_clk,
  output reg        tick
);
  reg  [5:0] cnt_reg;
  reg        ext_prev_reg;
  reg  [5:0] last;
  wire       ext_rise;
  wire       advance;

  assign ext_rise = ext_clk & ~ext_prev_reg;
  assign advance  = (sca == `TSM_SCA_EXT8) ? ext_rise : 1'b1;

  always @*
  begin
    case (sca)
      `TSM_SCA_DIV12: last = `TSM_LAST_DIV12;
      `TSM_SCA_DIV4:  last = `TSM_LAST_DIV4;
      `TSM_SCA_DIV48: last = `TSM_LAST_DIV48;
      default:        last = `TSM_LAST_EXT8;
    endcase
  end

  // >= keeps the divider sane after a scale change
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg      <= `TSM_RST_CNT;
      ext_prev_reg <= 1'b0;
      tick         <= 1'b0;
    end
    else if (ce)
    begin
      ext_prev_reg <= ext_clk;
      if (advance && (cnt_reg >= last))
      begin
        cnt_reg <= `TSM_RST_CNT;
        tick    <= 1'b1;
      end
      else if (advance)
      begin
        cnt_reg <= cnt_reg + 6'h01;
        tick    <= 1'b0;
      end
      else
        tick <= 1'b0;
    end
  end
endmodule

/* File: rtl/tsm_ext_irq.v */
// one external interrupt input: polarity, edge/level detect and sticky flag
`timescale 1ns/100ps
module tsm_ext_irq (
  input  wire mclk,
  input  wire rst,
  input  wire ce,
  input  wire irq_pin,
  input  wire polarity,
  input  wire edge_mode,
  input  wire sw_wr,
  input  wire sw_val,
  input  wire vec_ack,
  output wire active,
  output reg  flag
);
  reg  act_prev_reg;
  wire act_edge;
  wire hw_set;
  wire clr;

  assign active   = polarity ? irq_pin : ~irq_pin; // R14
  assign act_edge = active & ~act_prev_reg;
  assign hw_set   = edge_mode ? act_edge : active; // R13 R16
  assign clr      = (sw_wr & ~sw_val) | (vec_ack & edge_mode); // R16

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      act_prev_reg <= 1'b0;
      flag         <= 1'b0;
    end
    else if (ce)
    begin
      act_prev_reg <= active;
      // hardware set beats a clear in the same cycle
      if (hw_set || (sw_wr && sw_val))
        flag <= 1'b1; // R16
      else if (clr)
        flag <= 1'b0;
    end
  end
endmodule

/* File: rtl/tsm_timer_core.v */
// timer 0/1 core with split mode, control register and external interrupts
`timescale 1ns/100ps
`include "tsm_map.vh"
module tsm_timer_core (
  input  wire       mclk,
  input  wire       rst,
  input  wire       ce,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  input  wire [7:0] bit_addr,
  input  wire       bit_wr,
  input  wire       bit_wdata,
  input  wire       timer0_count_pin,
  input  wire       timer1_count_pin,
  input  wire       ext_irq0_input,
  input  wire       ext_irq1_input,
  input  wire       ext_irq0_polarity,
  input  wire       ext_irq1_polarity,
  input  wire       ext_prescale_clk,
  input  wire       vec_timer0,
  input  wire       vec_timer1,
  input  wire       vec_ext0,
  input  wire       vec_ext1,
  output wire       timer0_irq,
  output wire       timer1_irq,
  output wire       ext_irq0_flag,
  output wire       ext_irq1_flag,
  output reg        timer1_ovf_pulse
);
  reg  [7:0]  timer_mode_register_reg;
  reg  [7:0]  clock_control_register_reg;
  reg  [7:0]  tl0_reg;
  reg  [7:0]  th0_reg;
  reg  [7:0]  tl1_reg;
  reg  [7:0]  th1_reg;
  reg         timer0_run;
  reg         timer1_run;
  reg         timer0_overflow_flag;
  reg         timer1_overflow_flag;
  reg         ext_irq0_type;
  reg         ext_irq1_type;
  reg         t0_pin_prev_reg;
  reg         t1_pin_prev_reg;
  reg  [7:0]  timer_control_view;
  reg  [7:0]  rdata_next;

  wire [7:0]  timer_control_we;
  wire [7:0]  timer_control_wv;
  wire        timer_control_byte_wr;
  wire        timer_control_bit_hit;
  wire        presc_tick;
  wire        ext0_active;
  wire        ext1_active;
  wire [1:0]  t0_mode;
  wire [1:0]  t1_mode;
  wire        split;
  wire        t0_fall;
  wire        t1_fall;
  wire        t0_timer_tick;
  wire        t1_timer_tick;
  wire        t0_run_ok;
  wire        t1_run_ok;
  wire        t0_inc;
  wire        th0_inc;
  wire        t1_inc;
  wire [16:0] t0_res;
  wire [16:0] t1_res;
  wire [8:0]  tl0_split_sum;
  wire [8:0]  th0_split_sum;
  wire        t0_ovf;
  wire        th0_ovf;
  wire        t1_ovf;
  wire        tf1_set;

  // one counting step of a timer in modes 0, 1 and 2; mode 3 holds
  function [16:0] tsm_step;
    input [15:0] v;
    input [1:0]  m;
    reg   [13:0] c13;
    reg   [8:0]  c8;
    reg   [16:0] c16;
    begin
      c13 = {1'b0, v[15:8], v[`TSM_TL13_MSB:0]} + 14'h0001;
      c8  = {1'b0, v[7:0]} + 9'h001;
      c16 = {1'b0, v} + 17'h0_0001;
      case (m)
        `TSM_MODE_13:
          tsm_step = {c13[13], c13[12:5], v[7:`TSM_TL13_PAD], c13[4:0]};
        `TSM_MODE_16:
          tsm_step = c16;
        `TSM_MODE_RLD:
          tsm_step = {c8[8], v[15:8], (c8[8] ? v[15:8] : c8[7:0])};
        default:
          tsm_step = {1'b0, v};
      endcase
    end
  endfunction

  // byte and bit writes to the control register
  assign timer_control_byte_wr = sfr_wr & (sfr_addr == `TSM_ADDR_TIMER_CONTROL); // R15
  assign timer_control_bit_hit = bit_wr & (bit_addr[7:3] == `TSM_ADDR_TIMER_CONTROL >> 3); // R15
  assign timer_control_we = timer_control_byte_wr ? `TSM_BYTE_ONES :
                   (timer_control_bit_hit ? (`TSM_BIT_ONE << bit_addr[2:0]) : `TSM_BYTE_ZERO);
  assign timer_control_wv = timer_control_byte_wr ? sfr_wdata : {8{bit_wdata}};

  tsm_prescaler u_presc (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .sca     (clock_control_register_reg[`TSM_CK_SCA_HI:`TSM_CK_SCA_LO]),
    .ext_clk (ext_prescale_clk),
    .tick    (presc_tick)
  );

  tsm_ext_irq u_ext0 (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .irq_pin   (ext_irq0_input),
    .polarity  (ext_irq0_polarity),
    .edge_mode (ext_irq0_type),
    .sw_wr     (timer_control_we[`TSM_TC_IE0]),
    .sw_val    (timer_control_wv[`TSM_TC_IE0]),
    .vec_ack   (vec_ext0),
    .active    (ext0_active),
    .flag      (ext_irq0_flag)
  );

  tsm_ext_irq u_ext1 (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .irq_pin   (ext_irq1_input),
    .polarity  (ext_irq1_polarity),
    .edge_mode (ext_irq1_type),
    .sw_wr     (timer_control_we[`TSM_TC_IE1]),
    .sw_val    (timer_control_wv[`TSM_TC_IE1]),
    .vec_ack   (vec_ext1),
    .active    (ext1_active),
    .flag      (ext_irq1_flag)
  );

  assign t0_mode = timer_mode_register_reg[`TSM_TM_M0_HI:`TSM_TM_M0_LO]; // R17
  assign t1_mode = timer_mode_register_reg[`TSM_TM_M1_HI:`TSM_TM_M1_LO]; // R17
  assign split   = (t0_mode == `TSM_MODE_SPLIT); // R01

  assign t0_fall = t0_pin_prev_reg & ~timer0_count_pin; // R19
  assign t1_fall = t1_pin_prev_reg & ~timer1_count_pin; // R19

  // system clock or prescaled tick
  assign t0_timer_tick = clock_control_register_reg[`TSM_CK_T0SYS] | presc_tick; // R18
  assign t1_timer_tick = clock_control_register_reg[`TSM_CK_T1SYS] | presc_tick; // R18

  // run enable: run bit, plus active external input when gate is set; timer 1 in split mode ignores both
  assign t0_run_ok = timer0_run & (~timer_mode_register_reg[`TSM_TM_TIMER0_GATE_ENABLE] | ext0_active); // R12 R20 R02
  assign t1_run_ok = split ? (t1_mode != `TSM_MODE_SPLIT) : // R09
                     (timer1_run & (~timer_mode_register_reg[`TSM_TM_GATE1] | ext1_active)); // R12 R20

  assign t0_inc = t0_run_ok &
                  (timer_mode_register_reg[`TSM_TM_CT0] ? t0_fall : t0_timer_tick); // R03 R02
  assign th0_inc = split & timer1_run & t0_timer_tick; // R04 R05
  assign t1_inc = t1_run_ok & (t1_mode != `TSM_MODE_SPLIT) &
                  ((timer_mode_register_reg[`TSM_TM_CT1] & ~split) ? t1_fall : t1_timer_tick); // R07

  assign t0_res = tsm_step({th0_reg, tl0_reg}, t0_mode);
  assign t1_res = tsm_step({th1_reg, tl1_reg}, t1_mode);
  assign tl0_split_sum = {1'b0, tl0_reg} + 9'h001; // R01
  assign th0_split_sum = {1'b0, th0_reg} + 9'h001; // R01

  assign t0_ovf  = t0_inc & (split ? tl0_split_sum[8] : t0_res[16]); // R02
  assign th0_ovf = th0_inc & th0_split_sum[8];
  assign t1_ovf  = t1_inc & t1_res[16];
  assign tf1_set = split ? th0_ovf : t1_ovf; // R06 R07

  assign timer0_irq = timer0_overflow_flag;
  assign timer1_irq = timer1_overflow_flag; // R06

  // mode and clock registers
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      timer_mode_register_reg  <= `TSM_RST_BYTE;
      clock_control_register_reg <= `TSM_RST_BYTE;
    end
    else if (ce)
    begin
      if (sfr_wr && (sfr_addr == `TSM_ADDR_TIMER_MODE_REGISTER))
        timer_mode_register_reg <= sfr_wdata;
      if (sfr_wr && (sfr_addr == `TSM_ADDR_CLOCK_CONTROL_REGISTER))
        clock_control_register_reg <= sfr_wdata;
    end
  end

  // control register bits; hardware set wins over any clear
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      timer0_run           <= 1'b0;
      timer1_run           <= 1'b0;
      ext_irq0_type        <= 1'b0;
      ext_irq1_type        <= 1'b0;
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (timer_control_we[`TSM_TC_TR0])
        timer0_run <= timer_control_wv[`TSM_TC_TR0]; // R12
      if (timer_control_we[`TSM_TC_TR1])
        timer1_run <= timer_control_wv[`TSM_TC_TR1]; // R12
      if (timer_control_we[`TSM_TC_IT0])
        ext_irq0_type <= timer_control_wv[`TSM_TC_IT0]; // R13
      if (timer_control_we[`TSM_TC_IT1])
        ext_irq1_type <= timer_control_wv[`TSM_TC_IT1]; // R13
      if (t0_ovf)
        timer0_overflow_flag <= 1'b1; // R10
      else if (timer_control_we[`TSM_TC_TF0])
        timer0_overflow_flag <= timer_control_wv[`TSM_TC_TF0]; // R11
      else if (vec_timer0)
        timer0_overflow_flag <= 1'b0; // R11
      if (tf1_set)
        timer1_overflow_flag <= 1'b1; // R10 R06
      else if (timer_control_we[`TSM_TC_TF1])
        timer1_overflow_flag <= timer_control_wv[`TSM_TC_TF1]; // R11
      else if (vec_timer1)
        timer1_overflow_flag <= 1'b0; // R11
    end
  end

  // counters; a register write beats a count in the same cycle
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tl0_reg          <= `TSM_RST_BYTE;
      th0_reg          <= `TSM_RST_BYTE;
      tl1_reg          <= `TSM_RST_BYTE;
      th1_reg          <= `TSM_RST_BYTE;
      t0_pin_prev_reg  <= 1'b0;
      t1_pin_prev_reg  <= 1'b0;
      timer1_ovf_pulse <= 1'b0;
    end
    else if (ce)
    begin
      t0_pin_prev_reg  <= timer0_count_pin;
      t1_pin_prev_reg  <= timer1_count_pin;
      timer1_ovf_pulse <= t1_ovf; // R08
      if (sfr_wr && (sfr_addr == `TSM_ADDR_TL0))
        tl0_reg <= sfr_wdata;
      else if (t0_inc && split)
        tl0_reg <= tl0_split_sum[7:0]; // R01 R02
      else if (t0_inc)
        tl0_reg <= t0_res[7:0];
      if (sfr_wr && (sfr_addr == `TSM_ADDR_TH0))
        th0_reg <= sfr_wdata;
      else if (th0_inc)
        th0_reg <= th0_split_sum[7:0]; // R04 R05
      else if (t0_inc && !split)
        th0_reg <= t0_res[15:8];
      if (sfr_wr && (sfr_addr == `TSM_ADDR_TL1))
        tl1_reg <= sfr_wdata;
      else if (t1_inc)
        tl1_reg <= t1_res[7:0];
      if (sfr_wr && (sfr_addr == `TSM_ADDR_TH1))
        th1_reg <= sfr_wdata;
      else if (t1_inc)
        th1_reg <= t1_res[15:8];
    end
  end

  // read path
  always @*
  begin
    timer_control_view = `TSM_BYTE_ZERO;
    timer_control_view[`TSM_TC_TF1] = timer1_overflow_flag;
    timer_control_view[`TSM_TC_TR1] = timer1_run;
    timer_control_view[`TSM_TC_TF0] = timer0_overflow_flag;
    timer_control_view[`TSM_TC_TR0] = timer0_run;
    timer_control_view[`TSM_TC_IE1] = ext_irq1_flag;
    timer_control_view[`TSM_TC_IT1] = ext_irq1_type;
    timer_control_view[`TSM_TC_IE0] = ext_irq0_flag;
    timer_control_view[`TSM_TC_IT0] = ext_irq0_type;
    case (sfr_addr)
      `TSM_ADDR_TIMER_CONTROL:  rdata_next = timer_control_view; // R15
      `TSM_ADDR_TIMER_MODE_REGISTER:  rdata_next = timer_mode_register_reg;
      `TSM_ADDR_TL0:   rdata_next = tl0_reg;
      `TSM_ADDR_TL1:   rdata_next = tl1_reg;
      `TSM_ADDR_TH0:   rdata_next = th0_reg;
      `TSM_ADDR_TH1:   rdata_next = th1_reg;
      `TSM_ADDR_CLOCK_CONTROL_REGISTER: rdata_next = clock_control_register_reg;
      default:         rdata_next = `TSM_BYTE_ZERO;
    endcase
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      sfr_rdata <= `TSM_BYTE_ZERO;
    else if (ce && sfr_rd)
      sfr_rdata <= rdata_next;
  end
endmodule

/* File: bench/tsm_core_asserts.sv */
// concurrent checks on the timer core ports
`timescale 1ns/100ps
module tsm_core_asserts (
  input logic       mclk,
  input logic       rst,
  input logic       ce,
  input logic [7:0] sfr_addr,
  input logic       sfr_wr,
  input logic       sfr_rd,
  input logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata,
  input logic [7:0] bit_addr,
  input logic       bit_wr,
  input logic       bit_wdata,
  input logic       ext_irq0_input,
  input logic       ext_irq0_polarity,
  input logic       vec_ext0,
  input logic       timer0_irq,
  input logic       timer1_irq,
  input logic       ext_irq0_flag,
  input logic       timer1_ovf_pulse
);
  logic [7:0] ctl_reg;
  logic [7:0] mode_reg;
  logic       ctl_wr;
  logic       act0;
  assign ctl_wr = ce && ((sfr_wr && sfr_addr == 8'h88) || (bit_wr && bit_addr[7:3] == 5'h11));
  assign act0 = ext_irq0_input == ext_irq0_polarity;
  // software-owned control and mode bits
  always @(posedge mclk or posedge rst)
    if (rst)
      {ctl_reg, mode_reg} <= 16'h0000;
    else if (ce)
    begin
      if (sfr_wr && sfr_addr == 8'h88)
        ctl_reg <= sfr_wdata;
      else if (bit_wr && bit_addr[7:3] == 5'h11)
        ctl_reg[bit_addr[2:0]] <= bit_wdata;
      if (sfr_wr && sfr_addr == 8'h89)
        mode_reg <= sfr_wdata;
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ctl_read_back: assert property (
    ce && sfr_rd && sfr_addr == 8'h88 && !ctl_wr |=> sfr_rdata[6] == ctl_reg[6] &&
    sfr_rdata[4] == ctl_reg[4] && sfr_rdata[2] == ctl_reg[2] && sfr_rdata[0] == ctl_reg[0])
    else $error("control read back wrong");
  a_run0_off_quiet: assert property (
    ce && !ctl_reg[4] && !timer0_irq && !ctl_wr |=> !timer0_irq)
    else $error("timer0 flag set while stopped");
  a_high_byte_gate: assert property (
    ce && mode_reg[1:0] == 2'b11 && !ctl_reg[6] && !timer1_irq && !ctl_wr |=> !timer1_irq)
    else $error("timer1 flag set in split with run bit clear");
  a_timer1_mode_stop: assert property (
    (ce && mode_reg[5:4] == 2'b11) [*2] |=> !timer1_ovf_pulse)
    else $error("timer1 pulse while stopped");
  a_level_sets_flag: assert property (
    ce && !ctl_reg[0] && act0 && !ctl_wr |=> ext_irq0_flag)
    else $error("level input did not set flag");
  a_edge_no_set: assert property (
    ce && ctl_reg[0] && !act0 && !ext_irq0_flag && !ctl_wr |=> !ext_irq0_flag)
    else $error("edge flag set without edge");
  a_edge_vec_clear: assert property (
    ce && ctl_reg[0] && !act0 && vec_ext0 && !ctl_wr |=> !ext_irq0_flag)
    else $error("edge flag kept after vector");
  a_level_vec_keep: assert property (
    ce && !ctl_reg[0] && ext_irq0_flag && vec_ext0 && !ctl_wr |=> ext_irq0_flag)
    else $error("level flag cleared by vector");
  c_split_pulse: cover property (mode_reg[1:0] == 2'b11 && timer1_ovf_pulse);
  c_edge_vector: cover property (ctl_reg[0] && vec_ext0);
  c_high_flag: cover property (mode_reg[1:0] == 2'b11 && $rose(timer1_irq));
endmodule

/* File: bench/tsm_cpu_model.sv */
// processor core stand-in that vectors to pending interrupts
`timescale 1ns/100ps
module tsm_cpu_model (
  input  logic       mclk,
  input  logic       rst,
  input  logic       ack_en,
  input  logic [7:0] ack_delay,
  input  logic       timer0_irq,
  input  logic       timer1_irq,
  input  logic       ext_irq0_flag,
  input  logic       ext_irq1_flag,
  output logic       vec_timer0,
  output logic       vec_timer1,
  output logic       vec_ext0,
  output logic       vec_ext1
);
  logic [3:0] req;
  logic [3:0] vec_reg;
  logic [7:0] wait_reg;
  assign req = {timer1_irq, ext_irq1_flag, timer0_irq, ext_irq0_flag} & {4{ack_en}};
  assign {vec_timer1, vec_ext1, vec_timer0, vec_ext0} = vec_reg;
  // one-cycle vector pulse after a set delay, highest priority first
  always @(posedge mclk or posedge rst)
    if (rst || vec_reg != 4'h0 || req == 4'h0)
      {vec_reg, wait_reg} <= 12'h000;
    else if (wait_reg < ack_delay)
      wait_reg <= wait_reg + 8'h01;
    else
      vec_reg <= req & (~req + 4'h1);
endmodule

/* File: bench/timer_split_mode_control_tb.sv */
// self-checking bench for the timer split-mode core
`timescale 1ns/100ps
module timer_split_mode_control_tb;
  logic       mclk = 1'b0, rst = 1'b1, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic       bit_wr = 1'b0, bit_wdata = 1'b0, pin0 = 1'b1, ack_en = 1'b0;
  logic       irq0 = 1'b0, irq1 = 1'b0, pol0 = 1'b1, pol1 = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, ack_delay = 8'h00;
  logic [7:0] sfr_rdata, hits;
  logic       ovf0, ovf1, xf0, xf1, pulse, vt0, vt1, ve0, ve1, x, p, t;
  int         bad_count = 0, compares = 0, cycles = 0;
  wire  [4:0] flags = {pulse, xf1, xf0, ovf1, ovf0};
  tsm_timer_core tsm_timer_core_inst (
    .mclk(mclk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
    .bit_wdata(bit_wdata), .timer0_count_pin(pin0), .timer1_count_pin(1'b1),
    .ext_irq0_input(irq0), .ext_irq1_input(irq1), .ext_irq0_polarity(pol0),
    .ext_irq1_polarity(pol1), .ext_prescale_clk(1'b0), .vec_timer0(vt0), .vec_timer1(vt1),
    .vec_ext0(ve0), .vec_ext1(ve1), .timer0_irq(ovf0), .timer1_irq(ovf1),
    .ext_irq0_flag(xf0), .ext_irq1_flag(xf1), .timer1_ovf_pulse(pulse));
  tsm_cpu_model tsm_cpu_model_inst (
    .mclk(mclk), .rst(rst), .ack_en(ack_en), .ack_delay(ack_delay), .timer0_irq(ovf0),
    .timer1_irq(ovf1), .ext_irq0_flag(xf0), .ext_irq1_flag(xf1), .vec_timer0(vt0),
    .vec_timer1(vt1), .vec_ext0(ve0), .vec_ext1(ve1));
  always #20 mclk = ~mclk;
  task automatic finish_test;
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      finish_test;
    end
  end
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // byte write, or single-bit write when bw is set
  task automatic wr(input logic bw, input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    bit_addr = a;
    sfr_wdata = d;
    bit_wdata = d[0];
    {sfr_wr, bit_wr} = {~bw, bw};
    @(negedge mclk);
    {sfr_wr, bit_wr} = 2'b00;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    chk8(n, e, sfr_rdata);
    @(negedge mclk);
  endtask
  task automatic wait_fl(input int s, input int lim);
    for (int i = 0; i < lim && flags[s] !== 1'b1; i++)
      @(negedge mclk);
  endtask
  // the unused external channel is held inactive
  task automatic drive(input logic c, input logic pl, input logic v);
    {pol0, pol1} = {pl, pl};
    irq0 = c ? ~pl : v;
    irq1 = c ? v : ~pl;
  endtask
  initial
  begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    for (int a = 8'h88; a <= 8'h8e; a++)
      rd(8'(a), 8'h00, "reset value");
    wr(1'b0, 8'h90, 8'hff);
    rd(8'h90, 8'h00, "unmapped");
    wr(1'b1, 8'h88, 8'h01);
    wr(1'b1, 8'h8a, 8'h01);
    wr(1'b1, 8'h91, 8'h01);
    rd(8'h88, 8'h05, "bit writes");
    wr(1'b0, 8'h88, 8'h00);
    wr(1'b0, 8'h89, 8'h03);
    wr(1'b0, 8'h8e, 8'h04);
    wr(1'b0, 8'h8a, 8'hf0);
    wr(1'b1, 8'h8c, 8'h01);
    repeat (8) @(negedge mclk);
    chk1("low byte early", 1'b0, ovf0);
    wait_fl(0, 20);
    chk1("low byte flag", 1'b1, ovf0);
    chk1("high flag idle", 1'b0, ovf1);
    rd(8'h8c, 8'h00, "high byte idle");
    wr(1'b1, 8'h8c, 8'h00);
    wr(1'b1, 8'h8d, 8'h00);
    rd(8'h88, 8'h00, "flag cleared");
    wr(1'b0, 8'h89, 8'h07);
    wr(1'b0, 8'h8c, 8'hfe);
    wr(1'b1, 8'h8e, 8'h01);
    wait_fl(1, 20);
    chk1("high byte flag", 1'b1, ovf1);
    chk1("low byte quiet", 1'b0, ovf0);
    ack_en = 1'b1;
    repeat (4) @(negedge mclk);
    ack_en = 1'b0;
    chk1("flag after vector", 1'b0, ovf1);
    wr(1'b1, 8'h8e, 8'h00);
    wr(1'b0, 8'h8a, 8'hfd);
    wr(1'b1, 8'h8c, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      chk1("pin count early", 1'b0, ovf0);
      pin0 = 1'b0;
      repeat (2) @(negedge mclk);
      pin0 = 1'b1;
      repeat (2) @(negedge mclk);
    end
    chk1("pin count flag", 1'b1, ovf0);
    rd(8'h8a, 8'h00, "pin count wrap");
    wr(1'b1, 8'h8c, 8'h00);
    wr(1'b1, 8'h8d, 8'h00);
    wr(1'b0, 8'h8e, 8'h0c);
    for (int m = 0; m < 3; m++)
    begin
      wr(1'b0, 8'h89, 8'hf3);
      wr(1'b0, 8'h8b, 8'hff);
      wr(1'b0, 8'h8d, 8'hff);
      wr(1'b0, 8'h89, {2'b11, 2'(m), 4'h3});
      wait_fl(4, 8);
      chk1("timer1 pulse", 1'b1, pulse);
      chk1("timer1 flag", 1'b0, ovf1);
    end
    wr(1'b0, 8'h89, 8'hf3);
    repeat (2) @(negedge mclk);
    hits = 8'h00;
    for (int i = 0; i < 20; i++)
    begin
      hits = hits + {7'h00, pulse};
      @(negedge mclk);
    end
    chk8("stopped pulses", 8'h00, hits);
    ack_delay = 8'h03;
    for (int i = 0; i < 8; i++)
    begin
      {x, p, t} = 3'(i);
      drive(x, p, ~p);
      wr(1'b1, {5'h11, 1'b0, x, 1'b0}, {7'h00, t});
      wr(1'b1, {5'h11, 1'b0, x, 1'b1}, 8'h00);
      chk1("ext idle", 1'b0, flags[2 + x]);
      drive(x, p, p);
      repeat (2) @(negedge mclk);
      chk1("ext set", 1'b1, flags[2 + x]);
      drive(x, p, ~p);
      ack_en = 1'b1;
      repeat (8) @(negedge mclk);
      ack_en = 1'b0;
      @(negedge mclk);
      chk1("ext after vector", ~t, flags[2 + x]);
      wr(1'b1, {5'h11, 1'b0, x, 1'b1}, 8'h00);
      chk1("ext cleared", 1'b0, flags[2 + x]);
    end
    // gate on timer 0 low byte: held while the external input is inactive
    wr(1'b0, 8'h89, 8'hfb);
    wr(1'b0, 8'h8a, 8'hfe);
    wr(1'b1, 8'h8c, 8'h01);
    repeat (4) @(negedge mclk);
    rd(8'h8a, 8'hfe, "gate closed");
    irq0 = 1'b1;
    wait_fl(0, 8);
    chk1("gate open flag", 1'b1, ovf0);
    finish_test;
  end
endmodule
bind tsm_timer_core tsm_core_asserts tsm_core_asserts_inst (
  .mclk(mclk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
  .bit_wdata(bit_wdata), .ext_irq0_input(ext_irq0_input),
  .ext_irq0_polarity(ext_irq0_polarity), .vec_ext0(vec_ext0), .timer0_irq(timer0_irq),
  .timer1_irq(timer1_irq), .ext_irq0_flag(ext_irq0_flag), .timer1_ovf_pulse(timer1_ovf_pulse));
